// >>> hw/gmrb_bank.sv
// gas monitor register bank: APB slave holding range, units, state word,
// scaling, calibration figures, displayed and lowest gas and event times
// assumes the sensing core drives the sense struct synchronous to sys_clk
//
// Behaviour
// - the unit register accepts 1 for percent_lower_explosive_limit and 2 for percent_by_volume.
// - the state word carries one separate bit for each module state.
// - a state word with no bit set counts as a fault just like trouble.
// - bits 0x10 and 0x20 mark calibration running and calibration passed.
// - a failed calibration shows 0x40 and a passed one shows 0x20.
// - the scale register is read-only and always holds 1.
// - the calibration reference level is host writable, scaled like gas.
// - the days-to-calibration count falls daily and below zero means overdue.
// - the display register mirrors the shown gas value, also in calibration.
// - the lowest gas value seen is kept in a read-only register.
`timescale 1ns/1ps
`include "gmrb_map.svh"

module gmrb_bank #(
  parameter int unsigned SEC_CYCLES  = `GMRB_SEC_CYCLES,
  parameter int unsigned DAY_SECONDS = `GMRB_DAY_SECONDS
) (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  input  wire gmrb_pkg::gmrb_sense_s sense,
  output logic                       irq,
  output logic                       fault,
  output logic [15:0]                rangeSel,
  output logic [15:0]                unitSel,
  output logic [15:0]                calRef
);

  gmrb_pkg::gmrb_bank_s st;
  gmrb_pkg::gmrb_bank_s next_st;

  logic [15:0] alarmHigh;
  logic [15:0] alarmLow;
  logic [15:0] warnHigh;
  logic [15:0] warnLow;
  logic        readAlarmHigh;
  logic        readWarnHigh;
  logic        setupRead;
  logic [15:0] stateWord;
  logic [4:0]  events;

  // true when the bus address selects the register at this index
  function automatic logic addr_hit(input logic [31:0] addr,
                                    input logic [15:0] idx);
    addr_hit = (addr == {14'h0000, idx, 2'b00});
  endfunction : addr_hit

  // one bit per module state, calibration result kept by the fsm
  function automatic logic [15:0] build_state(
      input gmrb_pkg::gmrb_sense_s s,
      input gmrb_pkg::gmrb_cal_e   c);
    logic [15:0] w;
    w = 16'h0000;
    w[`GMRB_ST_RUN]      = s.runNormal;
    w[`GMRB_ST_ALARM]    = s.alarmActive;
    w[`GMRB_ST_WARNING]  = s.warningActive;
    w[`GMRB_ST_TROUBLE]  = s.trouble;
    w[`GMRB_ST_CAL_BUSY] = (c == gmrb_pkg::CAL_BUSY);
    w[`GMRB_ST_CAL_PASS] = (c == gmrb_pkg::CAL_PASSED);
    w[`GMRB_ST_CAL_FAIL] = (c == gmrb_pkg::CAL_FAILED);
    build_state = w;
  endfunction : build_state

  // read strobe of the upper timer halves, one per read access
  assign setupRead     = psel && penable && !st.pready && !pwrite;
  assign readAlarmHigh = setupRead && addr_hit(paddr, `GMRB_IDX_ALARM_HI);
  assign readWarnHigh  = setupRead && addr_hit(paddr, `GMRB_IDX_WARN_HI);
  assign stateWord     = build_state(sense, st.cal);

  // alarm and warning duration counters
  gmrb_event_timer u_alarm_timer (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .active   (sense.alarmActive),
    .secTick  (st.secTick),
    .readHigh (readAlarmHigh),
    .highHalf (alarmHigh),
    .lowHalf  (alarmLow)
  );

  gmrb_event_timer u_warn_timer (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .active   (sense.warningActive),
    .secTick  (st.secTick),
    .readHigh (readWarnHigh),
    .highHalf (warnHigh),
    .lowHalf  (warnLow)
  );

  // next state of the whole bank
  always_comb begin
    logic        dayTick;
    logic        calPassNow;
    logic        calFailNow;
    logic        overdueNow;
    logic        faultNow;
    logic        access;
    logic        commit;
    logic [31:0] rd;
    logic        hit;
    logic [15:0] wd;
    dayTick    = 1'b0;
    calPassNow = 1'b0;
    calFailNow = 1'b0;
    overdueNow = 1'b0;
    faultNow   = 1'b0;
    access     = 1'b0;
    commit     = 1'b0;
    rd         = 32'h0000_0000;
    hit        = 1'b1;
    wd         = pwdata[15:0];
    next_st    = st;

    // one second prescaler and day counter
    next_st.secTick = 1'b0;
    if (st.secDiv >= SEC_CYCLES - 1) begin
      next_st.secDiv  = 32'h0000_0000;
      next_st.secTick = 1'b1;
    end else begin
      next_st.secDiv = st.secDiv + 32'h0000_0001;
    end
    if (st.secTick) begin
      if (st.daySecs >= DAY_SECONDS - 1) begin
        next_st.daySecs = 32'h0000_0000;
        dayTick         = 1'b1;
      end else begin
        next_st.daySecs = st.daySecs + 32'h0000_0001;
      end
    end

    // calibration progress
    case (st.cal)
      gmrb_pkg::CAL_BUSY: begin
        if (sense.calFail) begin
          next_st.cal = gmrb_pkg::CAL_FAILED;
          calFailNow  = 1'b1;
        end else if (sense.calPass) begin
          next_st.cal = gmrb_pkg::CAL_PASSED;
          calPassNow  = 1'b1;
        end
      end
      gmrb_pkg::CAL_IDLE,
      gmrb_pkg::CAL_PASSED,
      gmrb_pkg::CAL_FAILED: begin
        if (sense.calStart) begin
          next_st.cal = gmrb_pkg::CAL_BUSY;
        end
      end
      default: begin
        next_st.cal = gmrb_pkg::CAL_IDLE;
      end
    endcase

    // count successful calibrations and restart the due countdown
    if (calPassNow) begin
      next_st.calCount = st.calCount + 16'h0001;
      next_st.daysLeft = 16'(`GMRB_CAL_DAYS);
    end else if (dayTick && (st.daysLeft != 16'h8000)) begin
      next_st.daysLeft = st.daysLeft - 16'h0001;
      overdueNow       = (st.daysLeft == 16'h0000);
    end

    // displayed and lowest gas, updated on each fresh sample
    if (sense.sampleValid) begin
      next_st.display = sense.display;
      if (sense.sample < st.lowest) begin
        next_st.lowest = sense.sample;
      end
    end

    // fault when trouble is flagged or no state bit is set
    faultNow      = sense.trouble || (stateWord == 16'h0000);
    next_st.fault = faultNow;
    next_st.prevAlarm = sense.alarmActive;

    // bus: answer one cycle into the access phase, commit on handshake
    access = psel && penable && !st.pready;
    commit = psel && penable && st.pready && pwrite;
    next_st.pready = access;
    if (access) begin
      case (1'b1)
        addr_hit(paddr, `GMRB_IDX_RANGE):      rd[15:0] = st.rangeSel;
        addr_hit(paddr, `GMRB_IDX_UNITS):      rd[15:0] = st.unitSel;
        addr_hit(paddr, `GMRB_IDX_STATE):      rd[15:0] = stateWord;
        addr_hit(paddr, `GMRB_IDX_SCALE):      rd[15:0] = st.scale;
        addr_hit(paddr, `GMRB_IDX_CALREF):     rd[15:0] = st.calRef;
        addr_hit(paddr, `GMRB_IDX_CALDAYS):    rd[15:0] = st.daysLeft;
        addr_hit(paddr, `GMRB_IDX_CALCOUNT):   rd[15:0] = st.calCount;
        addr_hit(paddr, `GMRB_IDX_DISPLAY):    rd[15:0] = st.display;
        addr_hit(paddr, `GMRB_IDX_LOWEST):     rd[15:0] = st.lowest;
        addr_hit(paddr, `GMRB_IDX_ALARM_HI):   rd[15:0] = alarmHigh;
        addr_hit(paddr, `GMRB_IDX_WARN_HI):    rd[15:0] = warnHigh;
        addr_hit(paddr, `GMRB_IDX_ALARM_LO):   rd[15:0] = alarmLow;
        addr_hit(paddr, `GMRB_IDX_WARN_LO):    rd[15:0] = warnLow;
        addr_hit(paddr, `GMRB_IDX_IRQ_STATUS): rd[4:0]  = st.irqStatus;
        addr_hit(paddr, `GMRB_IDX_IRQ_CLEAR):  rd[4:0]  = 5'h00;
        addr_hit(paddr, `GMRB_IDX_IRQ_ENABLE): rd[4:0]  = st.irqEnable;
        default:                               hit      = 1'b0;
      endcase
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd;
      next_st.pslverr = !hit;
    end else begin
      next_st.pslverr = 1'b0;
    end

    // register writes; read-only registers ignore writes
    if (commit) begin
      if (addr_hit(paddr, `GMRB_IDX_RANGE)) begin
        next_st.rangeSel = wd;
      end
      if (addr_hit(paddr, `GMRB_IDX_UNITS) &&
          ((wd == `GMRB_UNIT_LEL) || (wd == `GMRB_UNIT_VOL))) begin
        next_st.unitSel = wd;
      end
      if (addr_hit(paddr, `GMRB_IDX_CALREF)) begin
        next_st.calRef = wd;
      end
      if (addr_hit(paddr, `GMRB_IDX_IRQ_ENABLE)) begin
        next_st.irqEnable = wd[4:0];
      end
      if (addr_hit(paddr, `GMRB_IDX_IRQ_CLEAR)) begin
        next_st.irqStatus = st.irqStatus & ~wd[4:0];
      end
    end

    // sticky events; a new event beats a clear in the same cycle
    events = 5'h00;
    events[`GMRB_EV_CAL_PASS] = calPassNow;
    events[`GMRB_EV_CAL_FAIL] = calFailNow;
    events[`GMRB_EV_OVERDUE]  = overdueNow;
    events[`GMRB_EV_ALARM]    = sense.alarmActive && !st.prevAlarm;
    events[`GMRB_EV_FAULT]    = faultNow && !st.fault;
    next_st.irqStatus = next_st.irqStatus | events;
    next_st.irq       = |(next_st.irqStatus & next_st.irqEnable);
  end

  // register the whole bank
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st           <= '0;
      st.rangeSel  <= `GMRB_RST_RANGE;
      st.unitSel   <= `GMRB_RST_UNITS;
      st.scale     <= `GMRB_RST_SCALE;
      st.calRef    <= `GMRB_RST_CALREF;
      st.daysLeft  <= 16'(`GMRB_CAL_DAYS);
      st.lowest    <= `GMRB_RST_LOWEST;
      st.cal       <= gmrb_pkg::CAL_IDLE;
      st.fault     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state
  assign pready   = st.pready;
  assign pslverr  = st.pslverr;
  assign prdata   = st.prdata;
  assign irq      = st.irq;
  assign fault    = st.fault;
  assign rangeSel = st.rangeSel;
  assign unitSel  = st.unitSel;
  assign calRef   = st.calRef;

endmodule : gmrb_bank

// >>> hw/gmrb_map.svh
// register map, field positions, reset values and timing figures of the
// gas monitor register bank; included by the bank and its timer module
`ifndef GMRB_MAP_SVH
`define GMRB_MAP_SVH

// register indices; byte address on the bus is four times the index
`define GMRB_IDX_RANGE        16'h9C55
`define GMRB_IDX_UNITS        16'h9C56
`define GMRB_IDX_STATE        16'h9C57
`define GMRB_IDX_SCALE        16'h9C58
`define GMRB_IDX_CALREF       16'h9C59
`define GMRB_IDX_CALDAYS      16'h9C5A
`define GMRB_IDX_CALCOUNT     16'h9C5B
`define GMRB_IDX_DISPLAY      16'h9C5C
`define GMRB_IDX_LOWEST       16'h9C5D
`define GMRB_IDX_ALARM_HI     16'h9C5F
`define GMRB_IDX_WARN_HI      16'h9C60
`define GMRB_IDX_ALARM_LO     16'h9C70
`define GMRB_IDX_WARN_LO      16'h9C71
`define GMRB_IDX_IRQ_STATUS   16'h9C80
`define GMRB_IDX_IRQ_CLEAR    16'h9C81
`define GMRB_IDX_IRQ_ENABLE   16'h9C82

// unit selection codes
`define GMRB_UNIT_LEL         16'h0001
`define GMRB_UNIT_VOL         16'h0002

// module state word bit positions
`define GMRB_ST_RUN           0
`define GMRB_ST_ALARM         1
`define GMRB_ST_WARNING       2
`define GMRB_ST_TROUBLE       3
`define GMRB_ST_CAL_BUSY      4
`define GMRB_ST_CAL_PASS      5
`define GMRB_ST_CAL_FAIL      6

// interrupt event bit positions
`define GMRB_EV_CAL_PASS      0
`define GMRB_EV_CAL_FAIL      1
`define GMRB_EV_OVERDUE       2
`define GMRB_EV_ALARM         3
`define GMRB_EV_FAULT         4
`define GMRB_EV_WIDTH         5

// reset values
`define GMRB_RST_RANGE        16'h0064
`define GMRB_RST_UNITS        16'h0001
`define GMRB_RST_SCALE        16'h0001
`define GMRB_RST_CALREF       16'h0000
`define GMRB_RST_LOWEST       16'hFFFF

// timing: clock rate, one second, one day, calibration interval
`define GMRB_CLK_HZ           100000000
`define GMRB_TICK_SEC         1
`define GMRB_SEC_CYCLES       (`GMRB_CLK_HZ * `GMRB_TICK_SEC)
`define GMRB_DAY_SECONDS      86400
`define GMRB_CAL_DAYS         365

`endif

// >>> hw/gmrb_pkg.sv
// types shared by the gas monitor register bank and its timer module
// assumes the map header supplies all numeric constants
package gmrb_pkg;

  // calibration progress, gray coded along idle-busy-pass
  typedef enum logic [1:0] {
    CAL_IDLE   = 2'b00,
    CAL_BUSY   = 2'b01,
    CAL_PASSED = 2'b11,
    CAL_FAILED = 2'b10
  } gmrb_cal_e;

  // condition and measurement reported by the sensing core
  typedef struct packed {
    logic        runNormal;
    logic        alarmActive;
    logic        warningActive;
    logic        trouble;
    logic        calStart;
    logic        calPass;
    logic        calFail;
    logic        sampleValid;
    logic [15:0] sample;
    logic [15:0] display;
  } gmrb_sense_s;

  // state of one event time counter
  typedef struct packed {
    logic [31:0] seconds;
    logic [15:0] lowShadow;
  } gmrb_timer_s;

  // whole state of the register bank
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [15:0] rangeSel;
    logic [15:0] unitSel;
    logic [15:0] scale;
    logic [15:0] calRef;
    logic [15:0] daysLeft;
    logic [15:0] calCount;
    logic [15:0] display;
    logic [15:0] lowest;
    gmrb_cal_e   cal;
    logic [31:0] secDiv;
    logic [31:0] daySecs;
    logic        secTick;
    logic [4:0]  irqStatus;
    logic [4:0]  irqEnable;
    logic        irq;
    logic        fault;
    logic        prevAlarm;
  } gmrb_bank_s;

endpackage : gmrb_pkg

// >>> hw/gmrb_event_timer.sv
// event time counter: counts whole seconds while its event is active
// assumes a one-cycle second tick and register reads from the bank
`timescale 1ns/1ps
`include "gmrb_map.svh"

module gmrb_event_timer (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        active,
  input  wire logic        secTick,
  input  wire logic        readHigh,
  output logic [15:0]      highHalf,
  output logic [15:0]      lowHalf
);

  gmrb_pkg::gmrb_timer_s st;
  gmrb_pkg::gmrb_timer_s next_st;

  // count seconds; a read of the upper half freezes the lower half
  always_comb begin
    next_st = st;
    if (active && secTick) begin
      next_st.seconds = st.seconds + 32'h0000_0001;
    end
    if (readHigh) begin
      next_st.lowShadow = st.seconds[15:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // halves presented to the bank
  assign highHalf = st.seconds[31:16];
  assign lowHalf  = st.lowShadow;

endmodule : gmrb_event_timer

// >>> testbench/gmrb_monitor.sv
// assertions on the ports of the gas monitor register bank
// assumes one apb wait state and registered outputs as in the bank
`timescale 1ns/1ps
`include "gmrb_map.svh"
module gmrb_monitor #(
  parameter int unsigned SEC_CYCLES  = 4,
  parameter int unsigned DAY_SECONDS = 3
) (
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [31:0]           prdata,
  input wire gmrb_pkg::gmrb_sense_s sense,
  input wire logic                  irq,
  input wire logic                  fault,
  input wire logic [15:0]           rangeSel,
  input wire logic [15:0]           unitSel,
  input wire logic [15:0]           calRef
);
  localparam logic [31:0] A_UNIT = {14'h0, `GMRB_IDX_UNITS, 2'h0};
  localparam logic [31:0] A_REF  = {14'h0, `GMRB_IDX_CALREF, 2'h0};
  localparam logic [31:0] A_SCL  = {14'h0, `GMRB_IDX_SCALE, 2'h0};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // a write completing at this edge
  wire logic wrDone = psel && penable && pready && pwrite;
  wire logic okUnit = pwdata[15:0] inside {16'h1, 16'h2};

  // apb answer timing
  AST_PREADY_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("no answer in second access cycle");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_PREADY_QUAL: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  // register contents
  AST_UNIT_LEGAL: assert property (unitSel == 16'h1 || unitSel == 16'h2)
    else $error("unit code outside the two legal codes");
  AST_UNIT_WRITE: assert property (wrDone && paddr == A_UNIT && okUnit
    |=> unitSel == $past(pwdata[15:0])) else $error("unit write lost");
  AST_UNIT_KEEP: assert property (wrDone && paddr == A_UNIT && !okUnit
    |=> $stable(unitSel)) else $error("illegal unit code taken");
  AST_CALREF_WRITE: assert property (wrDone && paddr == A_REF
    |=> calRef == $past(pwdata[15:0])) else $error("reference write lost");
  AST_SCALE_READ: assert property (pready && !pwrite && paddr == A_SCL
    |-> prdata == 32'h1) else $error("scale reads wrong");
  AST_FAULT_TROUBLE: assert property (sense.trouble [*3] |-> fault)
    else $error("trouble without fault");
  // main scenarios
  cover property (wrDone && paddr == A_UNIT);
  cover property (pready && pslverr);
  cover property ($rose(irq));
  cover property ($rose(fault));
endmodule : gmrb_monitor

bind gmrb_bank gmrb_monitor #(
  .SEC_CYCLES(SEC_CYCLES),
  .DAY_SECONDS(DAY_SECONDS)
) u_mon (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .sense(sense),
  .irq(irq), .fault(fault), .rangeSel(rangeSel), .unitSel(unitSel),
  .calRef(calRef));

// >>> testbench/tb.sv
// self-checking bench for the gas monitor register bank
// assumes one apb wait state; second and day counts are shortened
`timescale 1ns/1ps
`include "gmrb_map.svh"
module tb;
  logic                  sys_clk;
  logic                  resetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic                  pready;
  logic                  pslverr;
  logic                  irq;
  logic                  fault;
  logic                  err;
  logic [31:0]           paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic [31:0]           rdat;
  logic [15:0]           rangeSel;
  logic [15:0]           unitSel;
  logic [15:0]           calRef;
  logic [15:0]           uExp;
  logic [15:0]           lowExp;
  logic [15:0]           smp;
  gmrb_pkg::gmrb_sense_s sense;
  int                    errors;
  int                    checks;

  gmrb_bank #(.SEC_CYCLES(4), .DAY_SECONDS(3)) i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .sense(sense), .irq(irq),
    .fault(fault), .rangeSel(rangeSel), .unitSel(unitSel),
    .calRef(calRef));

  // free running 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // expected unit code after a write
  function automatic logic [15:0] uNext(input logic [15:0] c, d);
    return (d == 16'h1 || d == 16'h2) ? d : c;
  endfunction : uNext
  function automatic logic [15:0] minOf(input logic [15:0] a, b);
    return (b < a) ? b : a;
  endfunction : minOf

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer to a word index, waiting for ready
  task automatic apb(input logic w, input logic [15:0] ix,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {14'h0, ix, 2'h0};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) errors++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rd(input logic [15:0] ix, input logic [31:0] e);
    apb(1'h0, ix, 32'h0);
    chk(rdat, e);
  endtask : rd
  // read a register and compare the bits under a mask
  task automatic rdm(input logic [15:0] ix, input logic [31:0] m, e);
    apb(1'h0, ix, 32'h0);
    chk(rdat & m, e);
  endtask : rdm
  // one-cycle calibration pulses: start, pass, fail
  task automatic cal(input logic [2:0] k);
    sense.calStart <= k[0];
    sense.calPass <= k[1];
    sense.calFail <= k[2];
    @(posedge sys_clk);
    sense.calStart <= 1'h0;
    sense.calPass <= 1'h0;
    sense.calFail <= 1'h0;
  endtask : cal
  // wait for the registered level to settle, then look at fault or irq
  task automatic lvl(input logic e, input logic s);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, s ? irq : fault}, {31'h0, e});
  endtask : lvl
  task automatic print_verdict();
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    {sys_clk, resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    sense = '0;
    errors = 0;
    checks = 0;
    void'($urandom(32'h6760));
    repeat (16) @(posedge sys_clk);
    resetn <= 1'h1;
    rd(`GMRB_IDX_UNITS, 32'h1);
    rd(`GMRB_IDX_SCALE, 32'h1);
    rd(`GMRB_IDX_LOWEST, 32'hFFFF);
    apb(1'h1, `GMRB_IDX_SCALE, 32'h64);
    rd(`GMRB_IDX_SCALE, 32'h1);
    apb(1'h1, `GMRB_IDX_RANGE, 32'h3E8);
    rd(`GMRB_IDX_RANGE, 32'h3E8);
    apb(1'h0, 16'h9C5E, 32'h0);
    chk({31'h0, err}, 32'h1);
    // unit codes 0..3 first, then random units and references
    uExp = 16'h1;
    for (int i = 0; i < 12; i++) begin
      smp = (i < 4) ? 16'(i) : 16'($urandom_range(0, 3));
      apb(1'h1, `GMRB_IDX_UNITS, {16'h0, smp});
      uExp = uNext(uExp, smp);
      rd(`GMRB_IDX_UNITS, {16'h0, uExp});
      smp = 16'($urandom());
      apb(1'h1, `GMRB_IDX_CALREF, {16'h0, smp});
      rd(`GMRB_IDX_CALREF, {16'h0, smp});
    end
    // display mirror and running minimum
    lowExp = 16'hFFFF;
    for (int i = 0; i < 8; i++) begin
      smp = 16'($urandom());
      sense.sample <= smp;
      sense.display <= ~smp;
      sense.sampleValid <= 1'h1;
      @(posedge sys_clk);
      sense.sampleValid <= 1'h0;
      lowExp = minOf(lowExp, smp);
      rd(`GMRB_IDX_DISPLAY, {16'h0, ~smp});
      rd(`GMRB_IDX_LOWEST, {16'h0, lowExp});
    end
    // run state alone, empty state word, trouble
    sense.runNormal <= 1'h1;
    lvl(1'h0, 1'h0);
    rd(`GMRB_IDX_STATE, 32'h1);
    sense.runNormal <= 1'h0;
    lvl(1'h1, 1'h0);
    sense.runNormal <= 1'h1;
    sense.trouble <= 1'h1;
    lvl(1'h1, 1'h0);
    rdm(`GMRB_IDX_STATE, 32'h8, 32'h8);
    sense.trouble <= 1'h0;
    // calibration sequence with masked and cleared events
    apb(1'h1, `GMRB_IDX_IRQ_CLEAR, 32'h1F);
    apb(1'h1, `GMRB_IDX_IRQ_ENABLE, 32'h1);
    cal(3'h1);
    rdm(`GMRB_IDX_STATE, 32'h70, 32'h10);
    lvl(1'h0, 1'h1);
    cal(3'h2);
    rdm(`GMRB_IDX_STATE, 32'h70, 32'h20);
    rd(`GMRB_IDX_CALCOUNT, 32'h1);
    lvl(1'h1, 1'h1);
    cal(3'h2);
    cal(3'h1);
    cal(3'h4);
    rdm(`GMRB_IDX_STATE, 32'h70, 32'h40);
    rd(`GMRB_IDX_CALCOUNT, 32'h1);
    rd(`GMRB_IDX_IRQ_STATUS, 32'h3);
    apb(1'h1, `GMRB_IDX_IRQ_CLEAR, 32'h1);
    lvl(1'h0, 1'h1);
    apb(1'h1, `GMRB_IDX_IRQ_ENABLE, 32'h1F);
    lvl(1'h1, 1'h1);
    apb(1'h1, `GMRB_IDX_IRQ_CLEAR, 32'h1F);
    lvl(1'h0, 1'h1);
    // alarm time: ten seconds of four cycles
    sense.alarmActive <= 1'h1;
    repeat (40) @(posedge sys_clk);
    sense.alarmActive <= 1'h0;
    rd(`GMRB_IDX_ALARM_HI, 32'h0);
    apb(1'h0, `GMRB_IDX_ALARM_LO, 32'h0);
    chk({31'h0, rdat >= 32'h9 && rdat <= 32'hB}, 32'h1);
    rdm(`GMRB_IDX_IRQ_STATUS, 32'h8, 32'h8);
    // warning time: five seconds of four cycles
    sense.warningActive <= 1'h1;
    repeat (20) @(posedge sys_clk);
    sense.warningActive <= 1'h0;
    rd(`GMRB_IDX_WARN_HI, 32'h0);
    apb(1'h0, `GMRB_IDX_WARN_LO, 32'h0);
    chk({31'h0, rdat >= 32'h4 && rdat <= 32'h6}, 32'h1);
    // pass, then let the due count run below zero
    cal(3'h1);
    cal(3'h2);
    repeat (370 * 12) @(posedge sys_clk);
    rdm(`GMRB_IDX_CALDAYS, 32'h8000, 32'h8000);
    rdm(`GMRB_IDX_IRQ_STATUS, 32'h4, 32'h4);
    // reset in mid-run restores the writable copies
    resetn <= 1'h0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'h1;
    chk({rangeSel, unitSel}, 32'h00640001);
    chk({16'h0, calRef}, 32'h0);
    print_verdict();
  end
endmodule : tb
